/* File: core/unsm_ep_state.sv */
// state tracker of the control endpoint with stall answer
`timescale 1ns/1ps
module unsm_ep_state (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       setup_tok_i,
  input  wire logic       status_nak_i,
  input  wire logic       crc_err_i,
  input  wire logic       tx_timeout_i,
  input  wire logic       over_read_i,
  output logic      [2:0] state_code_o,
  output logic            stall_o
);
  unsm_pkg::unsm_state_e state_r;
  unsm_pkg::unsm_state_e state_nxt;

  // setup wins, then stall, error and busy
  always_comb begin
    state_nxt = state_r;
    if (setup_tok_i) begin
      state_nxt = unsm_pkg::UNSM_READY;
    end else if (over_read_i) begin
      state_nxt = unsm_pkg::UNSM_STALL;
    end else if (crc_err_i || tx_timeout_i) begin
      state_nxt = unsm_pkg::UNSM_ERROR;
    end else if (status_nak_i) begin
      state_nxt = unsm_pkg::UNSM_BUSY;
    end
  end

  // map state onto the visible code
  always_comb begin
    unique case (state_r)
      unsm_pkg::UNSM_READY: state_code_o = unsm_pkg::ST_READY;
      unsm_pkg::UNSM_BUSY:  state_code_o = unsm_pkg::ST_BUSY;
      unsm_pkg::UNSM_ERROR: state_code_o = unsm_pkg::ST_ERROR;
      unsm_pkg::UNSM_STALL: state_code_o = unsm_pkg::ST_STALL;
    endcase
  end

  // state register and stall handshake request
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= unsm_pkg::UNSM_READY;
      stall_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stall_o <= over_read_i && !setup_tok_i;
    end
  end
endmodule

/* File: core/unsm_pkg.sv */
// shared constants and types for the control endpoint status and nak mask
package unsm_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] NAK_FLAGS_OFS  = 8'h00;
  localparam logic [7:0] NAK_MASK_OFS   = 8'h04;
  localparam logic [7:0] CTRL_SIZE_OFS  = 8'h08;
  localparam logic [7:0] CTRL_STATE_OFS = 8'h0C;
  // field positions
  localparam int NAK_LSB      = 1;
  localparam int NAK_MSB      = 7;
  localparam int NUM_NAK_EP   = 7;
  localparam int ZLP_BIT      = 15;
  localparam int VALID_BIT    = 12;
  localparam int MAXPKT_MSB   = 6;
  localparam int LOCK_BIT     = 15;
  localparam int TOGGLE_LSB   = 12;
  localparam int STATE_LSB    = 9;
  // reset values
  localparam logic [31:0] REG_RST    = 32'h0000_0000;
  localparam logic [6:0]  MAXPKT_RST = 7'h00;
  // state codes of the control endpoint
  localparam logic [2:0] ST_READY = 3'h0;
  localparam logic [2:0] ST_BUSY  = 3'h1;
  localparam logic [2:0] ST_ERROR = 3'h2;
  localparam logic [2:0] ST_STALL = 3'h3;
  // toggle codes
  localparam logic [1:0] TOG_DATA0 = 2'h0;
  localparam logic [1:0] TOG_DATA1 = 2'h1;
  // apb access takes one wait cycle before pready
  localparam int APB_WAIT_CYCLES = 1;

  typedef enum logic [1:0] {
    UNSM_READY,
    UNSM_BUSY,
    UNSM_ERROR,
    UNSM_STALL
  } unsm_state_e;
endpackage

/* File: core/unsm_sticky.sv */
// vector of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module unsm_sticky #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] q_nxt;

  // set has priority over clear
  assign q_nxt = set_i | (q_o & ~clr_i);

  // flag storage
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= q_nxt;
    end
  end
endmodule

/* File: core/unsm_top.sv */
// nak interrupt masking and control endpoint config and status registers
//
// Overview of operation
// - for endpoints 1 to 7 a mask bit of zero passes the nak flag to the nak interrupt and a one blocks it.
// - a masked endpoint still gets its nak flag set but raises no nak interrupt.
// - a nak handshake sent on endpoint 1 to 7 sets that endpoint's nak flag; endpoint zero has none.
// - the zero length pending bit 15 sets on the send zero length command and clears once that packet is sent.
// - read only bit 12 shows valid data in the control fifo and clears on a setup token.
// - bits 6 to 0 hold the control endpoint max packet size that the controller uses.
// - the fifo write lock bit 15 sets on a setup token and clears on the setup acknowledge command.
// - while the write lock is one every write into the control fifo is refused.
// - bits 13 to 12 show the data toggle, 00 for data0 and 01 for data1.
// - bits 11 to 9 show the endpoint state and return to ready 000 on a setup token.
// - a nak sent in the status stage loads busy 001.
// - a crc error on received data or a timeout after sending loads error 010.
// - reading past the declared length loads stall 011 and asks for a stall answer.
`timescale 1ns/1ps
module unsm_top (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // events from the usb engine, one cycle pulses
  input  wire logic [6:0]  nak_tx_i,
  input  wire logic        setup_tok_i,
  input  wire logic        setup_ack_cmd_i,
  input  wire logic        send_zero_len_cmd_i,
  input  wire logic        zero_len_done_i,
  input  wire logic        fifo_wr_req_i,
  input  wire logic        fifo_drained_i,
  input  wire logic        toggle_flip_i,
  input  wire logic        status_nak_i,
  input  wire logic        crc_err_i,
  input  wire logic        tx_timeout_i,
  input  wire logic        over_read_i,
  // answers to the usb engine
  output logic             fifo_wr_ok_o,
  output logic [6:0]       max_pkt_o,
  output logic             zero_len_pend_o,
  output logic             stall_o,
  output logic             nak_irq_o
);
  // bus decode
  wire         acc_done  = psel_i && penable_i && pready_o;
  wire         hit_flags = paddr_i == unsm_pkg::NAK_FLAGS_OFS;
  wire         hit_mask  = paddr_i == unsm_pkg::NAK_MASK_OFS;
  wire         hit_size  = paddr_i == unsm_pkg::CTRL_SIZE_OFS;
  wire         hit_state = paddr_i == unsm_pkg::CTRL_STATE_OFS;
  wire         hit_any   = hit_flags | hit_mask | hit_size | hit_state;
  wire         wr_flags  = acc_done && pwrite_i && hit_flags;
  wire         wr_mask   = acc_done && pwrite_i && hit_mask;
  wire         wr_size   = acc_done && pwrite_i && hit_size;

  logic [6:0]  nak_flags;
  logic [6:0]  nak_mask_r;
  logic        zlp_pend;
  logic        fifo_valid;
  logic        wr_lock;
  logic [1:0]  toggle_r;
  logic [2:0]  state_code;
  logic        pready_nxt;
  logic [31:0] rdata_nxt;

  // nak flags, hardware set beats software write one to clear
  unsm_sticky #(
    .W(unsm_pkg::NUM_NAK_EP)
  ) u_nak_flags (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (nak_tx_i),
    .clr_i     (wr_flags ? pwdata_i[unsm_pkg::NAK_MSB:unsm_pkg::NAK_LSB]
                         : 7'h00),
    .q_o       (nak_flags)
  );

  // zero length packet pending bit
  unsm_sticky #(
    .W(1)
  ) u_zlp (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (send_zero_len_cmd_i),
    .clr_i     (zero_len_done_i),
    .q_o       (zlp_pend)
  );

  // fifo write lock, set by setup and released by the acknowledge
  unsm_sticky #(
    .W(1)
  ) u_lock (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (setup_tok_i),
    .clr_i     (setup_ack_cmd_i),
    .q_o       (wr_lock)
  );

  // fifo writes pass only while unlocked
  wire         wr_accept = fifo_wr_req_i && !wr_lock;

  // fifo data valid, cleared by setup or a drained fifo
  unsm_sticky #(
    .W(1)
  ) u_fifo_valid (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (wr_accept && !setup_tok_i),
    .clr_i     (setup_tok_i || fifo_drained_i),
    .q_o       (fifo_valid)
  );

  // control endpoint state field
  unsm_ep_state u_state (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .setup_tok_i  (setup_tok_i),
    .status_nak_i (status_nak_i),
    .crc_err_i    (crc_err_i),
    .tx_timeout_i (tx_timeout_i),
    .over_read_i  (over_read_i),
    .state_code_o (state_code),
    .stall_o      (stall_o)
  );

  // unmasked nak flags form the interrupt
  wire         nak_irq_nxt = |(nak_flags & ~nak_mask_r);

  // toggle restarts at data0 on setup, else flips per acked packet
  wire [1:0]   toggle_nxt = setup_tok_i ? unsm_pkg::TOG_DATA0 :
                            toggle_flip_i ? {1'b0, ~toggle_r[0]} :
                            toggle_r;

  // register views, reserved bits read zero
  wire [31:0]  flags_view = {24'h000000, nak_flags, 1'b0};
  wire [31:0]  mask_view  = {24'h000000, nak_mask_r, 1'b0};
  wire [31:0]  size_view  = {16'h0000, zlp_pend, 2'b00, fifo_valid, 5'h00,
                             max_pkt_o};
  wire [31:0]  state_view = {16'h0000, wr_lock, 1'b0, toggle_r,
                             state_code, 9'h000};

  // read data select
  assign rdata_nxt  = hit_flags ? flags_view :
                      hit_mask  ? mask_view  :
                      hit_size  ? size_view  :
                      hit_state ? state_view : 32'h0000_0000;
  assign pready_nxt = psel_i && penable_i && !pready_o;

  // apb answer after one wait cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= unsm_pkg::REG_RST;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= pready_nxt;
      prdata_o  <= pready_nxt && !pwrite_i ? rdata_nxt : 32'h0000_0000;
      pslverr_o <= pready_nxt && !hit_any;
    end
  end

  // software registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nak_mask_r <= 7'h00;
      max_pkt_o  <= unsm_pkg::MAXPKT_RST;
    end else begin
      if (wr_mask) begin
        nak_mask_r <= pwdata_i[unsm_pkg::NAK_MSB:unsm_pkg::NAK_LSB];
      end
      if (wr_size) begin
        max_pkt_o <= pwdata_i[unsm_pkg::MAXPKT_MSB:0];
      end
    end
  end

  // status outputs to the usb engine
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      toggle_r        <= unsm_pkg::TOG_DATA0;
      fifo_wr_ok_o    <= 1'b0;
      zero_len_pend_o <= 1'b0;
      nak_irq_o       <= 1'b0;
    end else begin
      toggle_r        <= toggle_nxt;
      fifo_wr_ok_o    <= wr_accept;
      zero_len_pend_o <= zlp_pend;
      nak_irq_o       <= nak_irq_nxt;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence nak_seen_s;
    |nak_tx_i;
  endsequence

  sequence flags_follow_s;
    ##1 ((nak_flags & $past(nak_tx_i)) == $past(nak_tx_i));
  endsequence

  // nak flag and interrupt checks
  irq_or_mask_a: assert property (
    ##1 nak_irq_o == |($past(nak_flags) & ~$past(nak_mask_r)))
    else $error("nak interrupt differs from unmasked flags");

  masked_quiet_a: assert property (
    (nak_mask_r == 7'h7F) [*2] |-> !nak_irq_o)
    else $error("fully masked flags raised the interrupt");

  nak_set_a: assert property (
    nak_seen_s |-> flags_follow_s)
    else $error("sent nak did not set its flag");

  nak_irq_lag_a: assert property (
    (|(nak_tx_i & ~nak_mask_r)) && !wr_mask |-> ##2 nak_irq_o)
    else $error("unmasked nak not seen on interrupt in two cycles");

  mask_load_a: assert property (
    wr_mask |=> nak_mask_r == $past(pwdata_i[7:1]))
    else $error("nak mask not loaded");

  // control endpoint config checks
  zlp_track_a: assert property (
    send_zero_len_cmd_i |=> zlp_pend ##1 zero_len_pend_o)
    else $error("zero length command did not set pending");

  zlp_clear_a: assert property (
    zero_len_done_i && !send_zero_len_cmd_i |=> !zlp_pend)
    else $error("zero length pending not cleared");

  zlp_out_a: assert property (
    ##1 zero_len_pend_o == $past(zlp_pend))
    else $error("zero length pending output lags wrongly");

  valid_clear_a: assert property (
    setup_tok_i |=> !fifo_valid)
    else $error("fifo valid survived a setup token");

  valid_set_a: assert property (
    fifo_wr_req_i && !wr_lock && !setup_tok_i |=> fifo_valid)
    else $error("accepted fifo write did not mark valid data");

  valid_drain_a: assert property (
    fifo_drained_i && !wr_accept |=> !fifo_valid)
    else $error("drained fifo still marked valid");

  maxpkt_load_a: assert property (
    wr_size |=> max_pkt_o == $past(pwdata_i[6:0]))
    else $error("max packet size not loaded");

  // control endpoint status checks
  lock_set_a: assert property (
    setup_tok_i |=> wr_lock)
    else $error("write lock not set by setup");

  lock_hold_a: assert property (
    wr_lock && !setup_ack_cmd_i |=> wr_lock)
    else $error("write lock dropped without acknowledge");

  lock_clear_a: assert property (
    setup_ack_cmd_i && !setup_tok_i |=> !wr_lock)
    else $error("write lock not cleared by acknowledge");

  lock_block_a: assert property (
    wr_lock && fifo_wr_req_i |=> !fifo_wr_ok_o)
    else $error("fifo write taken while locked");

  lock_pass_a: assert property (
    fifo_wr_req_i && !wr_lock |=> fifo_wr_ok_o)
    else $error("fifo write refused while unlocked");

  toggle_code_a: assert property (
    toggle_flip_i && !setup_tok_i |=>
      !toggle_r[1] && toggle_r[0] != $past(toggle_r[0]))
    else $error("toggle field out of range or stuck");

  toggle_setup_a: assert property (
    setup_tok_i |=> toggle_r == unsm_pkg::TOG_DATA0)
    else $error("setup did not restart toggle at data0");

  state_ready_a: assert property (
    setup_tok_i |=> state_code == unsm_pkg::ST_READY)
    else $error("setup token did not restore ready");

  state_busy_a: assert property (
    status_nak_i && !setup_tok_i && !over_read_i && !crc_err_i &&
      !tx_timeout_i |=> state_code == unsm_pkg::ST_BUSY)
    else $error("status nak did not load busy");

  state_err_a: assert property (
    (crc_err_i || tx_timeout_i) && !setup_tok_i && !over_read_i |=>
      state_code == unsm_pkg::ST_ERROR)
    else $error("crc error or timeout did not load error");

  state_stall_a: assert property (
    over_read_i && !setup_tok_i |=>
      state_code == unsm_pkg::ST_STALL && stall_o)
    else $error("over read did not load stall");

  stall_pulse_a: assert property (
    stall_o |-> $past(over_read_i) && !$past(setup_tok_i))
    else $error("stall answer without over read");
endmodule

/* File: tb/unsm_usb_model.sv */
// usb engine model that hands one-cycle event pulses to the block
`timescale 1ns/1ps
module unsm_usb_model (
  input  wire logic        ref_clk_i,
  output logic      [17:0] ev_o
);
  // all event lines idle low from time zero
  initial ev_o = 18'h00000;

  // raise the chosen events for exactly one cycle after a rising edge
  task automatic pulse(input logic [17:0] m);
    @(posedge ref_clk_i);
    ev_o <= m;
    @(posedge ref_clk_i);
    ev_o <= 18'h00000;
  endtask
endmodule

/* File: tb/usb_ctrl_ep_status_nak_mask_tb_top.sv */
// self-checking bench for the nak mask and control endpoint registers
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %0t got %h exp %h", $time, g, e); \
  end end
module usb_ctrl_ep_status_nak_mask_tb_top;
  localparam logic [7:0] FLG = unsm_pkg::NAK_FLAGS_OFS;
  localparam logic [7:0] MSK = unsm_pkg::NAK_MASK_OFS;
  localparam logic [7:0] SZC = unsm_pkg::CTRL_SIZE_OFS;
  localparam logic [7:0] STA = unsm_pkg::CTRL_STATE_OFS;
  logic        clk, rst, psel, pen, pwr, err;
  logic        pready, pslverr, wr_ok, zl_pend, stall, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, m;
  logic [6:0]  max_pkt;
  logic [17:0] ev;
  int          err_total, samples_checked;
  // event codes and state register readings, walked in order
  logic [17:0] sev [8] = '{18'h02000, 18'h02000, 18'h04000, 18'h08000,
                           18'h00080, 18'h10000, 18'h20000, 18'h00100};
  logic [31:0] sexp [8] = '{32'h9000, 32'h8000, 32'h8200, 32'h8400,
                            32'h8000, 32'h8400, 32'h8600, 32'h0600};

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  unsm_usb_model i_usb (.ref_clk_i(clk), .ev_o(ev));

  unsm_top i_dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .nak_tx_i(ev[6:0]), .setup_tok_i(ev[7]), .setup_ack_cmd_i(ev[8]),
    .send_zero_len_cmd_i(ev[9]), .zero_len_done_i(ev[10]),
    .fifo_wr_req_i(ev[11]), .fifo_drained_i(ev[12]),
    .toggle_flip_i(ev[13]), .status_nak_i(ev[14]), .crc_err_i(ev[15]),
    .tx_timeout_i(ev[16]), .over_read_i(ev[17]),
    .fifo_wr_ok_o(wr_ok), .max_pkt_o(max_pkt),
    .zero_len_pend_o(zl_pend), .stall_o(stall), .nak_irq_o(irq)
  );

  // one apb transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e);
  endtask

  task automatic gap(input int c);
    repeat (c) @(negedge clk);
  endtask

  // pulse events, then stop at the falling edge where one-cycle answers stand
  task automatic ev_go(input logic [17:0] x);
    i_usb.pulse(x);
    gap(1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog cuts a hung run short
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK(irq, 1'b0);
    rchk(FLG, 32'h0);
    rchk(MSK, 32'h0);
    rchk(SZC, 32'h0);
    rchk(STA, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    `CHK(err, 1'b1);
    apb(1'b1, SZC, 32'hFFFF_FFFF);
    rchk(SZC, 32'h0000_007F);
    `CHK(max_pkt, 7'h7F);
    apb(1'b1, STA, 32'hFFFF_FFFF);
    rchk(STA, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 7; k++) begin
      m = 32'h2 << k;
      ev_go(18'h1 << k);
      rchk(FLG, m);
      `CHK(irq, 1'b1);
      apb(1'b1, MSK, m);
      gap(2);
      `CHK(irq, 1'b0);
      apb(1'b1, FLG, m);
      apb(1'b1, MSK, 32'h0);
      rchk(FLG, 32'h0);
      `CHK(irq, 1'b0);
    end
    apb(1'b1, MSK, 32'hFE);
    ev_go(18'h0007F);
    rchk(FLG, 32'hFE);
    `CHK(irq, 1'b0);
    apb(1'b1, MSK, 32'h0);
    gap(2);
    `CHK(irq, 1'b1);
    apb(1'b1, FLG, 32'hFE);
    $display("test nak done");
    ev_go(18'h00800);
    `CHK(wr_ok, 1'b1);
    rchk(SZC, 32'h107F);
    ev_go(18'h00080);
    rchk(SZC, 32'h007F);
    rchk(STA, 32'h8000);
    ev_go(18'h00800);
    `CHK(wr_ok, 1'b0);
    rchk(SZC, 32'h007F);
    ev_go(18'h00100);
    rchk(STA, 32'h0);
    ev_go(18'h00800);
    `CHK(wr_ok, 1'b1);
    rchk(SZC, 32'h107F);
    ev_go(18'h01000);
    rchk(SZC, 32'h007F);
    ev_go(18'h00080);
    $display("test lock done");
    for (int i = 0; i < 8; i++) begin
      ev_go(sev[i]);
      `CHK(stall, sev[i][17]);
      rchk(STA, sexp[i]);
    end
    $display("test state done");
    ev_go(18'h00200);
    gap(1);
    `CHK(zl_pend, 1'b1);
    rchk(SZC, 32'h807F);
    ev_go(18'h00400);
    gap(1);
    `CHK(zl_pend, 1'b0);
    rchk(SZC, 32'h007F);
    $display("test zero length done");
    summarize();
  end
endmodule
